/* File: include/emb_map.svh */
// Register offsets, field positions and reset values of the external bus
`ifndef EMB_MAP_SVH
`define EMB_MAP_SVH
// ==========================================================
// Register offsets
`define EMB_TIMING_OFS    8'h8e
`define EMB_MODE_OFS      8'h8f
// Reset values
`define EMB_TIMING_RST    8'hff
`define EMB_MODE_RST      8'h4f
// Timing register fields
`define EMB_WID_HI        7
`define EMB_WID_LO        4
`define EMB_HOLD_HI       3
`define EMB_HOLD_LO       2
`define EMB_SET_HI        1
`define EMB_SET_LO        0
// Mode register fields
`define EMB_SZ_HI         6
`define EMB_SZ_LO         5
`define EMB_PROGRAM_STROBE_OPTION_BIT      3
`define EMB_MUX_BIT       2
`define EMB_WRITE_STROBE_ENABLE_BIT      1
`define EMB_AL_BIT        0
// Implemented bits of the mode register
`define EMB_MODE_MASK     8'h6f
// Address space encodings
`define EMB_SZ_FIFO       2'h0
`define EMB_SZ_8BIT       2'h1
`endif

/* File: include/emb_pkg.sv */
// Types shared by the external bus block
package emb_pkg;
  // ==========================================================
  // Access sequencer states
  typedef enum logic [2:0] {
    EMB_IDLE,
    EMB_LATCH,
    EMB_SETUP,
    EMB_STROBE,
    EMB_HOLD
  } emb_state_type;
endpackage

/* File: rtl/emb_ext_bus.sv */
// External memory bus sequencer with its configuration registers
`timescale 1ns/1ps
`include "emb_map.svh"

// Operation
// [RQ1] Sixteen bit address, multiplexed port with latch
// [RQ2] Separate program and data read strobes
// [RQ3] Multiplexed: high byte, shared low/data, strobes
// [RQ4] Non-multiplexed: separate high, low, data ports
// [RQ5] Eight bit mode: low address only
// [RQ6] FIFO mode: data and strobes, no address
// [RQ7] Space select: 00 FIFO, 01 8-bit, else 16
// [RQ8] Shared bit multiplexes address and data
// [RQ9] Strobe width is field plus one cycles
// [RQ10] Hold cycles after strobe from field
// [RQ11] Setup cycles before strobe from field
// [RQ12] Write enable bit gates write strobe
// [RQ13] Latch pulse one or two cycles
// [RQ14] Software writes reset value to unused bits
// [RQ15] Program strobe option only in multiplexed mode
// [RQ16] Order: address, setup, strobe, hold
// [RQ17] Memory drives read data before strobe ends
module emb_ext_bus
  import emb_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Core access request
  input  wire logic        acc_req,
  input  wire logic        acc_write,
  input  wire logic        acc_prog,
  input  wire logic [15:0] acc_addr,
  input  wire logic [7:0]  acc_wdata,
  output logic             acc_busy,
  output logic             acc_done,
  output logic      [7:0]  acc_rdata,
  // High address port
  output logic      [7:0]  high_addr_out,
  output logic             high_addr_oe,
  // Low address port
  output logic      [7:0]  low_addr_out,
  output logic             low_addr_oe,
  // Data port, two-way
  input  wire logic [7:0]  data_port_in,
  output logic      [7:0]  data_port_out,
  output logic             data_port_oe,
  // Strobe port
  output logic             addr_latch_strobe,
  output logic             program_fetch_strobe_n,
  output logic             wr_strobe_n,
  output logic             rd_strobe_n
);

  // ==========================================================
  // Configuration registers
  logic [7:0] timing_r;   // Timing configuration
  logic [7:0] mode_r;     // Mode configuration

  // Field decode
  wire  [3:0] wid_f  = timing_r[`EMB_WID_HI:`EMB_WID_LO];
  wire  [1:0] hold_f = timing_r[`EMB_HOLD_HI:`EMB_HOLD_LO];
  wire  [1:0] set_f  = timing_r[`EMB_SET_HI:`EMB_SET_LO];
  wire  [1:0] sz_f   = mode_r[`EMB_SZ_HI:`EMB_SZ_LO];
  wire        mux_f  = mode_r[`EMB_MUX_BIT];
  wire        program_strobe_option_f = mode_r[`EMB_PROGRAM_STROBE_OPTION_BIT];
  wire        write_strobe_enable_f = mode_r[`EMB_WRITE_STROBE_ENABLE_BIT];
  wire        al_f   = mode_r[`EMB_AL_BIT];

  // Mode decode, see [RQ7]
  wire        mode_fifo = (sz_f == `EMB_SZ_FIFO);
  wire        mode_8bit = (sz_f == `EMB_SZ_8BIT);
  wire        mode_16   = !mode_fifo && !mode_8bit;
  // Multiplexing only applies with a 16-bit space, see [RQ8]
  wire        mode_mux  = mode_16 && mux_f;
  // Program strobe option honoured in multiplexed mode, see [RQ15]
  wire        use_prog  = mode_mux && program_strobe_option_f;

  // Register decode
  wire        sel_tim   = (reg_addr == `EMB_TIMING_OFS);
  wire        sel_mode  = (reg_addr == `EMB_MODE_OFS);

  // Register writes; unused bits stay at reset value, see [RQ14]
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      timing_r <= `EMB_TIMING_RST;
      mode_r   <= `EMB_MODE_RST;
    end else if (clk_en && reg_wr) begin
      if (sel_tim) begin
        timing_r <= reg_wdata;
      end else if (sel_mode) begin
        mode_r <= (reg_wdata & `EMB_MODE_MASK) |
                  (`EMB_MODE_RST & ~`EMB_MODE_MASK);
      end
    end
  end

  // Read mux; unmapped addresses read zero
  wire [7:0] rd_sel = sel_tim  ? timing_r :
                      sel_mode ? mode_r   : 8'h00;

  // Read data register, valid one cycle after strobe
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_sel : 8'h00;
    end
  end

  // ==========================================================
  // Data port input synchroniser
  logic [7:0] din_s1_r;   // First stage
  logic [7:0] din_s2_r;   // Second stage

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      din_s1_r <= 8'h00;
      din_s2_r <= 8'h00;
    end else if (clk_en) begin
      din_s1_r <= data_port_in;
      din_s2_r <= din_s1_r;
    end
  end

  // ==========================================================
  // Access sequencer
  emb_state_type state_r;     // Current phase
  emb_state_type state_nxt;   // Next phase
  logic [3:0]    cnt_r;       // Phase cycle counter
  logic [3:0]    cnt_nxt;
  logic          wr_r;        // Latched direction
  logic          prog_r;      // Latched program access
  logic [15:0]   addr_r;      // Latched address
  logic [7:0]    wdat_r;      // Latched write data

  // Latch phase length minus one; setup and hold phase lengths
  wire  [3:0] lat_last = al_f ? 4'h1 : 4'h0;        // see [RQ13]
  wire  [3:0] set_len  = {2'b00, set_f};            // see [RQ11]
  wire  [3:0] hold_len = {2'b00, hold_f};           // see [RQ10]
  wire        last     = (state_r == EMB_STROBE) ? (cnt_r == wid_f) :
                         (cnt_r == 4'h0);

  // Sequencer next state, see [RQ16]
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      EMB_IDLE: begin
        if (acc_req) begin
          if (mode_mux) begin
            state_nxt = EMB_LATCH;
            cnt_nxt   = lat_last;
          end else if (set_len != 4'h0) begin
            state_nxt = EMB_SETUP;
            cnt_nxt   = set_len - 4'h1;
          end else begin
            state_nxt = EMB_STROBE;
            cnt_nxt   = 4'h0;
          end
        end
      end
      EMB_LATCH: begin
        if (cnt_r != 4'h0) begin
          cnt_nxt = cnt_r - 4'h1;
        end else if (set_len != 4'h0) begin
          state_nxt = EMB_SETUP;
          cnt_nxt   = set_len - 4'h1;
        end else begin
          state_nxt = EMB_STROBE;
        end
      end
      EMB_SETUP: begin
        if (!last) begin
          cnt_nxt = cnt_r - 4'h1;
        end else begin
          state_nxt = EMB_STROBE;
        end
      end
      EMB_STROBE: begin
        // Width counts up to field value, see [RQ9]
        if (!last) begin
          cnt_nxt = cnt_r + 4'h1;
        end else if (hold_len != 4'h0) begin
          state_nxt = EMB_HOLD;
          cnt_nxt   = hold_len - 4'h1;
        end else begin
          state_nxt = EMB_IDLE;
          cnt_nxt   = 4'h0;
        end
      end
      EMB_HOLD: begin
        if (!last) begin
          cnt_nxt = cnt_r - 4'h1;
        end else begin
          state_nxt = EMB_IDLE;
        end
      end
      default: begin
        state_nxt = EMB_IDLE;
        cnt_nxt   = 4'h0;
      end
    endcase
  end

  // State and latched request
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= EMB_IDLE;
      cnt_r   <= 4'h0;
      wr_r    <= 1'b0;
      prog_r  <= 1'b0;
      addr_r  <= 16'h0000;
      wdat_r  <= 8'h00;
    end else if (clk_en) begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      if (state_r == EMB_IDLE && acc_req) begin
        wr_r   <= acc_write;
        prog_r <= acc_prog && !acc_write;
        addr_r <= acc_addr;
        wdat_r <= acc_wdata;
      end
    end
  end

  // ==========================================================
  // Pin values derived from next state
  wire in_acc   = (state_nxt != EMB_IDLE);
  wire in_lat   = (state_nxt == EMB_LATCH);
  wire in_stb   = (state_nxt == EMB_STROBE);
  wire nx_wr    = (state_r == EMB_IDLE) ? acc_write : wr_r;
  wire nx_prog  = (state_r == EMB_IDLE) ? (acc_prog && !acc_write)
                                        : prog_r;
  wire [15:0] nx_addr = (state_r == EMB_IDLE) ? acc_addr : addr_r;
  wire [7:0]  nx_wdat = (state_r == EMB_IDLE) ? acc_wdata : wdat_r;

  // High byte only in 16-bit space, see [RQ3] [RQ4]
  wire        hi_oe   = in_acc && mode_16;
  // Low byte on its own port unless shared or FIFO, see [RQ4] [RQ5] [RQ6]
  wire        lo_oe   = in_acc && !mode_fifo && !mode_mux;
  // Shared port carries address during latch, see [RQ1] [RQ3]
  wire        d_oe    = in_acc && (in_lat ? 1'b1 : nx_wr);
  wire [7:0]  d_val   = in_lat ? nx_addr[7:0] : nx_wdat;
  // Write strobe gated by enable bit, see [RQ12]
  wire        wr_act  = in_stb && nx_wr && write_strobe_enable_f;
  // Program or data read strobe, see [RQ2] [RQ15]
  wire        rd_act  = in_stb && !nx_wr && !(use_prog && nx_prog);
  wire        ps_act  = in_stb && !nx_wr && use_prog && nx_prog;
  // Read data taken at last strobe cycle, see [RQ17]
  wire        rd_take = (state_r == EMB_STROBE) && last && !wr_r;
  wire        fin     = (state_r != EMB_IDLE) && (state_nxt == EMB_IDLE);

  // Registered pins and handshake
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      high_addr_out          <= 8'h00;
      high_addr_oe           <= 1'b0;
      low_addr_out           <= 8'h00;
      low_addr_oe            <= 1'b0;
      data_port_out          <= 8'h00;
      data_port_oe           <= 1'b0;
      addr_latch_strobe      <= 1'b0;
      program_fetch_strobe_n <= 1'b1;
      wr_strobe_n            <= 1'b1;
      rd_strobe_n            <= 1'b1;
      acc_busy               <= 1'b0;
      acc_done               <= 1'b0;
      acc_rdata              <= 8'h00;
    end else if (clk_en) begin
      high_addr_out          <= hi_oe ? nx_addr[15:8] : 8'h00;
      high_addr_oe           <= hi_oe;
      low_addr_out           <= lo_oe ? nx_addr[7:0] : 8'h00;
      low_addr_oe            <= lo_oe;
      data_port_out          <= d_oe ? d_val : 8'h00;
      data_port_oe           <= d_oe;
      addr_latch_strobe      <= in_lat;                 // see [RQ13]
      program_fetch_strobe_n <= !ps_act;
      wr_strobe_n            <= !wr_act;
      rd_strobe_n            <= !rd_act;
      acc_busy               <= in_acc;
      acc_done               <= fin;
      if (rd_take) begin
        acc_rdata <= din_s2_r;
      end
    end
  end

  // ==========================================================
  // Checks
  property p_latch_mux;
    @(posedge sys_clk) disable iff (srst)
      addr_latch_strobe |-> $past(mode_mux);
  endproperty
  a_latch_mux: assert property (p_latch_mux) // see [RQ1]
    else $error("latch outside mux");

  property p_fifo_noaddr;
    @(posedge sys_clk) disable iff (srst)
      $past(mode_fifo && clk_en) |-> !high_addr_oe && !low_addr_oe;
  endproperty
  a_fifo_noaddr: assert property (p_fifo_noaddr) // see [RQ6]
    else $error("address driven in FIFO mode");

  property p_8bit_nohigh;
    @(posedge sys_clk) disable iff (srst)
      $past(mode_8bit && clk_en) |-> !high_addr_oe;
  endproperty
  a_8bit_nohigh: assert property (p_8bit_nohigh) // see [RQ5]
    else $error("high byte driven in 8-bit mode");

  property p_strobe_excl;
    @(posedge sys_clk) disable iff (srst)
      !(!wr_strobe_n && !rd_strobe_n) && !(!rd_strobe_n &&
        !program_fetch_strobe_n);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl) // see [RQ2]
    else $error("two strobes at once");

  property p_prog_mux;
    @(posedge sys_clk) disable iff (srst)
      !program_fetch_strobe_n |-> $past(use_prog);
  endproperty
  a_prog_mux: assert property (p_prog_mux) // see [RQ15]
    else $error("program strobe outside mux mode");

  property p_write_strobe_enable;
    @(posedge sys_clk) disable iff (srst)
      !wr_strobe_n |-> $past(write_strobe_enable_f);
  endproperty
  a_write_strobe_enable: assert property (p_write_strobe_enable) // see [RQ12]
    else $error("write strobe while disabled");

  property p_wid_min;
    @(posedge sys_clk) disable iff (srst || !clk_en)
      $fell(rd_strobe_n) && wid_f != 4'h0 |-> ##1 !rd_strobe_n;
  endproperty
  a_wid_min: assert property (p_wid_min) // see [RQ9]
    else $error("strobe shorter than width");

  property p_order;
    @(posedge sys_clk) disable iff (srst)
      (state_r == EMB_STROBE) |-> $past(state_r) != EMB_HOLD;
  endproperty
  a_order: assert property (p_order) // see [RQ16]
    else $error("strobe after hold");

  property p_hold_addr;
    @(posedge sys_clk) disable iff (srst)
      (state_r == EMB_HOLD) |-> $stable(high_addr_out) &&
        $stable(low_addr_out) && $stable(data_port_out);
  endproperty
  a_hold_addr: assert property (p_hold_addr) // see [RQ10]
    else $error("address moved in hold");

  c_mux_read:  cover property (@(posedge sys_clk) $fell(addr_latch_strobe));
  c_write:     cover property (@(posedge sys_clk) $fell(wr_strobe_n));
  c_prog:      cover property (@(posedge sys_clk)
                               $fell(program_fetch_strobe_n));
  c_fifo_read: cover property (@(posedge sys_clk)
                               mode_fifo && $fell(rd_strobe_n));

endmodule

/* File: dv/emb_mem_model.sv */
// External memory partner: byte array or FIFO behind the strobes
`timescale 1ns/1ps
module emb_mem_model (
  // Clock
  input  wire logic       sys_clk,
  // Address pins
  input  wire logic [7:0] high_addr_out,
  input  wire logic       high_addr_oe,
  input  wire logic [7:0] low_addr_out,
  input  wire logic       low_addr_oe,
  // Data pins
  input  wire logic [7:0] data_port_out,
  input  wire logic       data_port_oe,
  // Strobes
  input  wire logic       addr_latch_strobe,
  input  wire logic       program_fetch_strobe_n,
  input  wire logic       wr_strobe_n,
  input  wire logic       rd_strobe_n,
  // Resolved bus
  output logic      [7:0] data_bus
);
  logic [7:0] mem [int];  // Storage
  logic [7:0] fq [$];     // FIFO contents
  logic [7:0] lat_r = 8'h00;  // Latched low address
  logic [7:0] wd_r;       // Write byte
  logic [7:0] last_r = 8'h00; // Last bus level, known from start
  logic       wlow_r;     // Write strobe was low
  logic       rlow_r;     // Read strobe was low
  logic       wf_r;       // Write hit FIFO
  logic       rf_r;       // Read hit FIFO
  int         wa_r;       // Write address
  int         addr;       // Address on pins
  logic [7:0] rq;         // Byte offered on read
  wire        rd_n = rd_strobe_n & program_fetch_strobe_n;
  wire        fifo = !high_addr_oe && !low_addr_oe;
  // Bus value: device, memory, else inverse of last level
  always @* begin
    addr = {high_addr_oe ? high_addr_out : 8'h00,
            low_addr_oe ? low_addr_out : lat_r};
    rq = fifo ? (fq.size() > 0 ? fq[0] : 8'h00)
              : (mem.exists(addr) ? mem[addr] : 8'h00);
    data_bus = data_port_oe ? data_port_out
                            : (!rd_n ? rq : ~last_r);
  end
  // Latch, capture and commit
  always @(posedge sys_clk) begin
    last_r <= data_bus;
    wlow_r <= !wr_strobe_n;
    rlow_r <= !rd_n;
    if (addr_latch_strobe) begin
      lat_r <= data_port_out;
    end
    if (!wr_strobe_n) begin
      wd_r <= data_port_out;
      wa_r <= addr;
      wf_r <= fifo;
    end
    if (!rd_n) begin
      rf_r <= fifo;
    end
    if (wr_strobe_n && wlow_r) begin
      if (wf_r) fq.push_back(wd_r);
      else mem[wa_r] = wd_r;
    end
    if (rd_n && rlow_r && rf_r && fq.size() > 0) begin
      void'(fq.pop_front());
    end
  end
endmodule

/* File: dv/external_memory_bus_tb.sv */
// Self-checking bench for the external memory bus sequencer
`timescale 1ns/1ps
`include "emb_map.svh"
module external_memory_bus_tb;
  // Clock, reset, register port
  logic sys_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, ce = 1;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  // Access port
  logic acc_req = 0, acc_write = 0, acc_prog = 0, acc_busy, acc_done;
  logic [15:0] acc_addr = 0;
  logic [7:0] acc_wdata = 0, acc_rdata;
  // Pins
  logic [7:0] hi_o, lo_o, d_in, d_out;
  logic hi_oe, lo_oe, d_oe, al_s, ps_n, wr_n, rd_n;
  // Bench state
  int err_count, check_count, cyc, n_al, n_rd, n_ps, n_wr, t_al, t_st, n_bad;
  int rw, hd, st, al, n_bz;
  logic seen_hi, seen_lo, addr_data_shared, program_strobe_option, write_strobe_enable;
  logic [1:0] sz;
  logic [15:0] cur, a;
  logic [7:0] rm [int];
  logic [7:0] rq [$];
  logic [4:0] tbl [6] = '{5'h17, 5'h1d, 5'h13, 5'h0f, 5'h03, 5'h12};

  always #2 sys_clk = ~sys_clk;

  emb_ext_bus u_dut (.sys_clk(sys_clk), .srst(srst), .clk_en(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_req(acc_req),
    .acc_write(acc_write), .acc_prog(acc_prog), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_busy(acc_busy), .acc_done(acc_done),
    .acc_rdata(acc_rdata), .high_addr_out(hi_o), .high_addr_oe(hi_oe),
    .low_addr_out(lo_o), .low_addr_oe(lo_oe), .data_port_in(d_in),
    .data_port_out(d_out), .data_port_oe(d_oe), .addr_latch_strobe(al_s),
    .program_fetch_strobe_n(ps_n), .wr_strobe_n(wr_n), .rd_strobe_n(rd_n));

  emb_mem_model u_mem (.sys_clk(sys_clk), .high_addr_out(hi_o),
    .high_addr_oe(hi_oe), .low_addr_out(lo_o), .low_addr_oe(lo_oe),
    .data_port_out(d_out), .data_port_oe(d_oe), .addr_latch_strobe(al_s),
    .program_fetch_strobe_n(ps_n), .wr_strobe_n(wr_n), .rd_strobe_n(rd_n),
    .data_bus(d_in));

  // Pin monitor, mid-cycle
  always @(negedge sys_clk) begin
    cyc++;
    if (al_s) begin
      if (n_al == 0) t_al = cyc;
      n_al++;
    end
    if ((!rd_n || !ps_n || !wr_n) && t_st == 0) t_st = cyc;
    n_rd += int'(!rd_n);
    n_ps += int'(!ps_n);
    n_wr += int'(!wr_n);
    n_bz += int'(acc_busy);
    seen_hi |= hi_oe;
    seen_lo |= lo_oe;
    if (hi_oe && hi_o !== cur[15:8]) n_bad++;
    if (lo_oe && lo_o !== cur[7:0]) n_bad++;
    if (al_s && d_out !== cur[7:0]) n_bad++;
  end

  // Compare and count
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  // Register write
  task automatic wr_reg(input logic [7:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Register read, data one cycle later
  task automatic rd_reg(input logic [7:0] ad, input logic [7:0] e,
                        input string nm);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, {8'h00, e}, {8'h00, reg_rdata});
  endtask

  // One access with timing, strobe and data checks
  task automatic acc(input logic w, input logic p, input logic [15:0] ad,
                     input logic [7:0] d);
    int n, l, wd, ea, sel;
    logic [7:0] e;
    l = (sz[1] && addr_data_shared) ? al + 1 : 0;
    wd = rw + 1;
    ea = sz[1] ? int'(ad) : (sz == 2'h1 ? int'(ad[7:0]) : 0);
    @(posedge sys_clk);
    {n_al, n_rd, n_ps, n_wr, n_bz, t_al, t_st, n_bad} = '0;
    {seen_hi, seen_lo} = 2'b00;
    cur = ad;
    acc_req <= 1'b1;
    acc_write <= w;
    acc_prog <= p;
    acc_addr <= ad;
    acc_wdata <= d;
    @(posedge sys_clk);
    acc_req <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (acc_done !== 1'b1 && n < 100);
    chk("cycles", 16'(l + st + wd + hd), 16'(n));
    chk("busy", 16'(l + st + wd + hd), 16'(n_bz));
    sel = w ? n_wr : ((p && program_strobe_option && sz[1] && addr_data_shared) ? n_ps : n_rd);
    chk("strobe", 16'((w && !write_strobe_enable) ? 0 : wd), 16'(sel));
    chk("other strobe", 0, 16'(n_rd + n_ps + n_wr - sel));
    chk("latch", 16'(l), 16'(n_al));
    if (l > 0) chk("order", 16'(l + st), 16'(t_st - t_al));
    chk("high oe", {15'h0, sz[1]}, {15'h0, seen_hi});
    chk("low oe", {15'h0, sz == 2'h1 || (sz[1] && !addr_data_shared)},
        {15'h0, seen_lo});
    chk("address", 0, 16'(n_bad));
    if (w && write_strobe_enable) begin
      if (sz == 2'h0) rq.push_back(d);
      else rm[ea] = d;
    end
    if (!w) begin
      if (sz == 2'h0) e = rq.size() > 0 ? rq.pop_front() : 8'h00;
      else e = rm.exists(ea) ? rm[ea] : 8'h00;
      chk("rdata", {8'h00, e}, {8'h00, acc_rdata});
    end
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog
  initial begin
    #200000;
    err_count++;
    conclude();
  end

  // Main sequence
  initial begin
    void'($urandom(70));
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    rd_reg(`EMB_TIMING_OFS, `EMB_TIMING_RST, "timing reset");
    rd_reg(`EMB_MODE_OFS, `EMB_MODE_RST, "mode reset");
    wr_reg(8'h90, 8'h5a);
    rd_reg(8'h90, 8'h00, "unmapped");
    rd_reg(`EMB_MODE_OFS, `EMB_MODE_RST, "mode kept");
    // Write while frozen must not land
    @(posedge sys_clk);
    ce <= 1'b0;
    wr_reg(`EMB_TIMING_OFS, 8'h00);
    ce <= 1'b1;
    rd_reg(`EMB_TIMING_OFS, `EMB_TIMING_RST, "frozen");
    foreach (tbl[i]) begin
      {sz, addr_data_shared, program_strobe_option, write_strobe_enable} = tbl[i];
      rw = 2 + $urandom % 14;
      hd = $urandom % 4;
      st = $urandom % 4;
      al = $urandom % 2;
      wr_reg(`EMB_TIMING_OFS, {4'(rw), 2'(hd), 2'(st)});
      wr_reg(`EMB_MODE_OFS,
             {1'b0, sz, 1'b0, program_strobe_option, addr_data_shared, write_strobe_enable, 1'(al)});
      rd_reg(`EMB_TIMING_OFS, {4'(rw), 2'(hd), 2'(st)}, "timing");
      a = 16'($urandom);
      acc(1'b1, 1'b0, a, 8'($urandom));
      acc(1'b1, 1'b0, a ^ 16'h0101, 8'($urandom));
      acc(1'b0, 1'b1, a, 8'h00);
      acc(1'b0, 1'b0, a ^ 16'h0101, 8'h00);
    end
    conclude();
  end
endmodule
